// ==== design/dos_top.sv ====
/*
 * Four directional phase overcurrent stages with remote pick-up scaling,
 * register access over AXI4-Lite.
 * Assumes measured phasor data on the same clock as aclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dos_consts.svh"

// Function
// - Scaling is either off (100 percent) or one value of 10..200.
// - With scaling on, group two equals group one, pick-up scaled.
// - The remote scaling value is an integer, one unit per percent.
// - Enabling scaling makes group two the active group.
// - Only the largest phase current is compared with pick-up.
// - Phase faults use the positive-sequence voltage/current angle.
// - Ground faults use faulted phase current and healthy voltage.
// - Modes are directional, non-directional and directional backup.
// - Backup mode goes non-directional once direction is lost.
// - Start when current over pick-up and angle within 88 degrees.
// - Trip when start has held longer than the operate delay.
// - Four independent stages with their own settings.
// - Stages one and two may use inverse time, three and four not.
// - Measured current saturates at 50 times nominal.
module dos_top #(
    parameter int unsigned TICK_CYC = `DOS_TICK_CYC,
    parameter int unsigned N_STAGE = 4
) (
    // Clock, reset and enable.
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Register bus.
    input wire dos_pkg::dos_axi_req_s axi_req,
    output dos_pkg::dos_axi_rsp_s axi_rsp,
    // Measurements.
    input wire dos_pkg::dos_meas_s meas,
    // Stage outputs.
    output logic [N_STAGE-1:0] start,
    output logic [N_STAGE-1:0] trip,
    output logic active_grp2
);
    import dos_pkg::*;

    typedef struct packed {
        dos_axi_rsp_s rsp;
        logic aw_h;
        logic [11:0] aw_a;
        logic w_h;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic scale_en;
        logic [7:0] pct;
        logic grp_sel;
        logic grp2;
        logic [31:0] tcnt;
        logic tick;
        logic [15:0] cur;
        logic signed [8:0] ang;
        logic dir_lost;
        dos_set_s [1:0][N_STAGE-1:0] set;
    } dos_top_s;

    dos_top_s st_r, st_nxt;
    logic [N_STAGE-1:0] pick;
    logic [N_STAGE-1:0] st_start, st_trip;

    ////////////////////////////////////////////////////////////////////////
    // Helper functions.

    function automatic logic [31:0] merge(input logic [31:0] old_w,
            input logic [31:0] new_w, input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic in_set(input logic [11:0] a);
        return a >= `DOS_SET_LO && a <= `DOS_SET_HI;
    endfunction

    function automatic logic [31:0] set_word(input dos_set_s s,
            input logic [1:0] f);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (f)
            `DOS_F_PICKUP: w[15:0] = s.pickup;
            `DOS_F_ANGLE: w[8:0] = s.angle;
            `DOS_F_CFG: w[2:0] = {s.inv_en, s.mode};
            `DOS_F_DELAY: w[15:0] = s.delay;
        endcase
        return w;
    endfunction

    function automatic dos_set_s set_put(input dos_set_s s,
            input logic [1:0] f, input logic [31:0] w);
        dos_set_s r;
        r = s;
        unique case (f)
            `DOS_F_PICKUP: r.pickup = w[15:0];
            `DOS_F_ANGLE: r.angle = w[8:0];
            `DOS_F_CFG: begin
                r.mode = (w[1:0] == 2'b11) ? DOS_DIR : dos_mode_e'(w[1:0]);
                r.inv_en = w[2];
            end
            `DOS_F_DELAY: r.delay = w[15:0];
        endcase
        return r;
    endfunction

    // Angle plus base, wrapped to one turn, tested against the sector.
    function automatic logic in_sector(input logic signed [8:0] ang,
            input logic signed [8:0] base);
        logic signed [9:0] d;
        d = 10'(ang) + 10'(base);
        if (d >= `DOS_HALF_TURN) begin
            d = d - `DOS_FULL_TURN;
        end else if (d < -`DOS_HALF_TURN) begin
            d = d + `DOS_FULL_TURN;
        end
        return d <= `DOS_SECTOR_DEG && d >= -`DOS_SECTOR_DEG;
    endfunction

    function automatic logic [15:0] max3(input logic [15:0] a,
            input logic [15:0] b, input logic [15:0] c);
        logic [15:0] m;
        m = (a > b) ? a : b;
        return (m > c) ? m : c;
    endfunction

    function automatic logic [15:0] scale(input logic [15:0] pu,
            input logic [7:0] pct);
        logic [23:0] p;
        p = (24'(pu) * 24'(pct)) / `DOS_PCT_UNIT;
        return (p > 24'h00_FFFF) ? 16'hFFFF : p[15:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    logic [31:0] rd_w, old_w, new_w;
    logic [15:0] imax, sat_lim;
    logic grp_of;
    logic [1:0] stg_of, fld_of;

    always_comb begin
        st_nxt = st_r;
        rd_w = 32'h0000_0000;
        old_w = 32'h0000_0000;
        new_w = 32'h0000_0000;
        grp_of = st_r.aw_a[6];
        stg_of = st_r.aw_a[5:4];
        fld_of = st_r.aw_a[3:2];

        // Write address and data are taken independently.
        if (axi_req.awvalid && st_r.rsp.awready) begin
            st_nxt.aw_h = 1'b1;
            st_nxt.aw_a = axi_req.awaddr;
        end
        if (axi_req.wvalid && st_r.rsp.wready) begin
            st_nxt.w_h = 1'b1;
            st_nxt.w_d = axi_req.wdata;
            st_nxt.w_s = axi_req.wstrb;
        end
        if (st_r.rsp.bvalid && axi_req.bready) begin
            st_nxt.rsp.bvalid = 1'b0;
        end
        if (st_r.aw_h && st_r.w_h && !st_r.rsp.bvalid) begin
            st_nxt.aw_h = 1'b0;
            st_nxt.w_h = 1'b0;
            st_nxt.rsp.bvalid = 1'b1;
            st_nxt.rsp.bresp = `DOS_RESP_OK;
            if (st_r.aw_a[11:2] == `DOS_CTRL_OFS >> 2) begin
                old_w = {15'h0000, st_r.grp_sel, st_r.pct, 7'h00,
                    st_r.scale_en};
                new_w = merge(old_w, st_r.w_d, st_r.w_s);
                st_nxt.scale_en = new_w[`DOS_CTRL_EN_BIT];
                st_nxt.grp_sel = new_w[`DOS_CTRL_GSEL_BIT];
                if (new_w[`DOS_CTRL_PCT_LSB +: 8] >= `DOS_PCT_MIN &&
                        new_w[`DOS_CTRL_PCT_LSB +: 8] <= `DOS_PCT_MAX) begin
                    st_nxt.pct = new_w[`DOS_CTRL_PCT_LSB +: 8];
                end
            end else if (in_set(st_r.aw_a) && !(grp_of && st_r.scale_en)
                    && 32'(stg_of) < N_STAGE) begin
                old_w = set_word(st_r.set[grp_of][stg_of], fld_of);
                new_w = merge(old_w, st_r.w_d, st_r.w_s);
                st_nxt.set[grp_of][stg_of] =
                    set_put(st_r.set[grp_of][stg_of], fld_of, new_w);
            end else if (st_r.aw_a[11:2] != `DOS_STAT_OFS >> 2 &&
                    !in_set(st_r.aw_a)) begin
                st_nxt.rsp.bresp = `DOS_RESP_SLVERR;
            end
        end

        // Reads answer one cycle after the address is taken.
        if (st_r.rsp.rvalid && axi_req.rready) begin
            st_nxt.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && st_r.rsp.arready) begin
            st_nxt.rsp.rvalid = 1'b1;
            st_nxt.rsp.rresp = `DOS_RESP_OK;
            if (axi_req.araddr[11:2] == `DOS_CTRL_OFS >> 2) begin
                rd_w = {15'h0000, st_r.grp_sel, st_r.pct, 7'h00,
                    st_r.scale_en};
            end else if (axi_req.araddr[11:2] == `DOS_STAT_OFS >> 2) begin
                rd_w[N_STAGE-1:0] = st_start;
                rd_w[N_STAGE +: N_STAGE] = st_trip;
                rd_w[2*N_STAGE] = st_r.grp2;
            end else if (in_set(axi_req.araddr)) begin
                if (32'(axi_req.araddr[5:4]) < N_STAGE) begin
                    rd_w = set_word(st_r.set[axi_req.araddr[6]]
                        [axi_req.araddr[5:4]], axi_req.araddr[3:2]);
                end
            end else begin
                st_nxt.rsp.rresp = `DOS_RESP_SLVERR;
            end
            st_nxt.rsp.rdata = rd_w;
        end
        st_nxt.rsp.awready = !st_nxt.aw_h && !st_nxt.rsp.bvalid;
        st_nxt.rsp.wready = !st_nxt.w_h && !st_nxt.rsp.bvalid;
        st_nxt.rsp.arready = !st_nxt.rsp.rvalid;

        // Group two follows group one with a scaled pick-up.
        if (st_nxt.scale_en) begin
            for (int s = 0; s < N_STAGE; s++) begin
                st_nxt.set[1][s] = st_nxt.set[0][s];
                st_nxt.set[1][s].pickup =
                    scale(st_nxt.set[0][s].pickup, st_nxt.pct);
            end
        end
        st_nxt.grp2 = st_nxt.scale_en || st_nxt.grp_sel;

        // Time base of the operate delays.
        st_nxt.tick = 1'b0;
        if (st_r.tcnt >= TICK_CYC - 1) begin
            st_nxt.tcnt = 32'h0000_0000;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.tcnt = st_r.tcnt + 32'h0000_0001;
        end

        // Measured values, registered once.
        sat_lim = 16'(`DOS_NOM_UNITS * `DOS_SAT_MULT);
        imax = max3(meas.ia, meas.ib, meas.ic);
        st_nxt.cur = (imax > sat_lim) ? sat_lim : imax;
        st_nxt.ang = meas.gnd_flt ? meas.ang_gnd :
            meas.ang_seq;
        st_nxt.dir_lost = meas.dir_lost;

        if (!ce) begin
            st_nxt = st_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.pct <= `DOS_PCT_RST;
            st_r.rsp.awready <= 1'b1;
            st_r.rsp.wready <= 1'b1;
            st_r.rsp.arready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stages.

    always_comb begin
        for (int s = 0; s < N_STAGE; s++) begin
            unique case (st_r.set[st_r.grp2][s].mode)
                DOS_UNDIR: pick[s] = 1'b1;
                DOS_BACKUP: pick[s] = st_r.dir_lost ||
                    in_sector(st_r.ang, st_r.set[st_r.grp2][s].angle);
                default: pick[s] = !st_r.dir_lost &&
                    in_sector(st_r.ang, st_r.set[st_r.grp2][s].angle);
            endcase
            pick[s] = pick[s] &&
                st_r.cur > st_r.set[st_r.grp2][s].pickup;
        end
    end

    for (genvar g = 0; g < N_STAGE; g++) begin : g_stage
        dos_delay u_delay (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .tick(st_r.tick),
            .pick(pick[g]),
            .inv_en(st_r.set[st_r.grp2][g].inv_en && g < 2),
            .cur(st_r.cur),
            .pickup(st_r.set[st_r.grp2][g].pickup),
            .delay(st_r.set[st_r.grp2][g].delay),
            .start(st_start[g]),
            .trip(st_trip[g])
        );
    end

    assign start = st_start;
    assign trip = st_trip;
    assign active_grp2 = st_r.grp2;
    assign axi_rsp = st_r.rsp;

endmodule
`default_nettype wire

// ==== design/dos_consts.svh ====
/*
 * Offsets, field positions, reset values and timing counts of the
 * directional overcurrent stage block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef DOS_CONSTS_SVH
`define DOS_CONSTS_SVH

`define DOS_CTRL_OFS 12'h000
`define DOS_STAT_OFS 12'h004
`define DOS_SET_LO 12'h100
`define DOS_SET_HI 12'h1FC
`define DOS_F_PICKUP 2'h0
`define DOS_F_ANGLE 2'h1
`define DOS_F_CFG 2'h2
`define DOS_F_DELAY 2'h3
`define DOS_CTRL_EN_BIT 0
`define DOS_CTRL_GSEL_BIT 16
`define DOS_CTRL_PCT_LSB 8
`define DOS_PCT_RST 8'h64
`define DOS_PCT_MIN 8'h0A
`define DOS_PCT_MAX 8'hC8
`define DOS_PCT_UNIT 24'h00_0064
`define DOS_SECTOR_DEG 10'sd88
`define DOS_HALF_TURN 10'sd180
`define DOS_FULL_TURN 10'sd360
`define DOS_NOM_UNITS 16'h0100
`define DOS_SAT_MULT 16'h0032
`define DOS_TICK_NS 1000000
`define DOS_CLK_NS 4
`define DOS_TICK_CYC (`DOS_TICK_NS / `DOS_CLK_NS)
`define DOS_RESP_OK 2'b00
`define DOS_RESP_SLVERR 2'b10

`endif

// ==== design/dos_pkg.sv ====
/*
 * Types of the directional overcurrent stage block.
 * Assumes dos_consts.svh for all numeric constants.
 */
package dos_pkg;

    typedef enum logic [1:0] {
        DOS_DIR,
        DOS_UNDIR,
        DOS_BACKUP
    } dos_mode_e;

    typedef struct packed {
        logic [15:0] pickup;
        logic signed [8:0] angle;
        dos_mode_e mode;
        logic inv_en;
        logic [15:0] delay;
    } dos_set_s;

    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } dos_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dos_axi_rsp_s;

    typedef struct packed {
        logic [15:0] ia;
        logic [15:0] ib;
        logic [15:0] ic;
        logic signed [8:0] ang_seq;
        logic signed [8:0] ang_gnd;
        logic gnd_flt;
        logic dir_lost;
    } dos_meas_s;

endpackage

// ==== design/dos_delay.sv ====
/*
 * Operate delay of one stage: definite or inverse time.
 * Assumes a one-cycle time base tick and a same-clock pick-up level.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dos_consts.svh"

module dos_delay (
    // Clock and control.
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic tick,
    // Stage inputs.
    input wire logic pick,
    input wire logic inv_en,
    input wire logic [15:0] cur,
    input wire logic [15:0] pickup,
    input wire logic [15:0] delay,
    // Stage outputs.
    output logic start,
    output logic trip
);
    import dos_pkg::*;

    typedef struct packed {
        logic [32:0] acc;
        logic start;
        logic trip;
    } dos_dly_s;

    dos_dly_s st_r, st_nxt;
    logic [32:0] inc, lim;

    always_comb begin
        st_nxt = st_r;
        inc = inv_en ? {17'h0_0000, cur} : 33'h0_0000_0001;
        lim = inv_en ? {1'b0, 32'(delay) * 32'(pickup)} :
            {17'h0_0000, delay};
        if (!pick) begin
            st_nxt = '0;
        end else begin
            st_nxt.start = 1'b1;
            if (tick && !st_r.acc[32]) begin
                st_nxt.acc = st_r.acc + inc;
            end
            if (st_r.acc > lim) begin
                st_nxt.trip = 1'b1;
            end
        end
        if (!ce) begin
            st_nxt = st_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign start = st_r.start;
    assign trip = st_r.trip;

endmodule
`default_nettype wire

// ==== testbench/dos_asserts.sv ====
/* Port checker of dos_top.
   Assumes a bind onto every dos_top instance. */
`timescale 1ns/1ps
`default_nettype none
module dos_asserts
    import dos_pkg::*;
#(
    parameter int unsigned TICK_CYC = 4,
    parameter int unsigned N_STAGE = 4
) (
    // Clock and control.
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Bus and measurements.
    input wire dos_pkg::dos_axi_req_s axi_req,
    input wire dos_pkg::dos_axi_rsp_s axi_rsp,
    input wire dos_pkg::dos_meas_s meas,
    // Stage outputs.
    input wire logic [N_STAGE-1:0] start,
    input wire logic [N_STAGE-1:0] trip,
    input wire logic active_grp2
);
////////////////////////////////////////
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
sequence wr_take;
    ce && axi_req.awvalid && axi_rsp.awready
        && axi_req.wvalid && axi_rsp.wready ##1 ce;
endsequence
sequence zero_in;
    ce && meas.ia == 0 && meas.ib == 0 && meas.ic == 0 ##1 ce;
endsequence
trip_with_start_a: assert property ((trip & ~start) == '0)
    else $error("trip without start");
trip_after_start_a: assert property (
    (trip & ~$past(trip) & ~$past(start)) == '0)
    else $error("trip rose without prior start");
idle_no_start_a: assert property (
    zero_in |=> start == '0 && trip == '0)
    else $error("start with zero current");
wr_resp_a: assert property (wr_take |=> axi_rsp.bvalid)
    else $error("write response late");
rd_resp_a: assert property (
    ce && axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read response late");
b_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready
    |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");
r_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready
    |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped");
w_busy_a: assert property (
    axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while busy");
r_busy_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken while busy");
endmodule
bind dos_top dos_asserts #(.TICK_CYC(TICK_CYC), .N_STAGE(N_STAGE)) chk_u (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .meas(meas), .start(start), .trip(trip),
    .active_grp2(active_grp2));
`default_nettype wire

// ==== testbench/tb_top.sv ====
/* Self-checking bench of dos_top, one task per scenario.
   Assumes the design files and the checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
import dos_pkg::*;
localparam int TK = 4;
logic aclk = 1'b0;
logic aresetn = 1'b0;
logic ce = 1'b1;
dos_axi_req_s rq = '0;
dos_axi_rsp_s rs;
dos_meas_s ms = '0;
logic [3:0] start;
logic [3:0] trip;
logic active_grp2;
int n_errors = 0;
int comparisons = 0;
logic [31:0] rd;
logic [1:0] rr;
int tb [9][6] = '{'{118, 0, 0, 0, 0, 1}, '{119, 0, 0, 0, 0, 0},
    '{-58, 0, 0, 0, 0, 1}, '{0, 118, 1, 0, 0, 1}, '{118, 119, 1, 0, 0, 0},
    '{119, 0, 0, 1, 2, 1}, '{119, 0, 0, 0, 2, 0}, '{119, 0, 0, 0, 1, 1},
    '{118, 0, 0, 1, 0, 0}};
always #2 aclk = ~aclk;
dos_top #(.TICK_CYC(TK), .N_STAGE(4)) dut_u (.aclk(aclk),
    .aresetn(aresetn), .ce(ce), .axi_req(rq), .axi_rsp(rs), .meas(ms),
    .start(start), .trip(trip), .active_grp2(active_grp2));
////////////////////////////////////////
task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
        n_errors++;
        $display("BAD %s exp %h got %h", nm, e, g);
    end
endtask
task automatic chk_rng(input string nm, input int lo, input int hi,
    input int g);
    comparisons++;
    if (g < lo || g > hi) begin
        n_errors++;
        $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
endtask
task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic aw_t, w_t, b_t;
    logic [1:0] br;
    @(posedge aclk);
    rq.awvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wvalid <= 1'b1;
    rq.wdata <= d;
    rq.wstrb <= 4'hF;
    rq.bready <= 1'b1;
    n = 0;
    do begin
        @(negedge aclk);
        aw_t = rq.awvalid && rs.awready;
        w_t = rq.wvalid && rs.wready;
        b_t = rs.bvalid;
        br = rs.bresp;
        @(posedge aclk);
        if (aw_t === 1'b1) rq.awvalid <= 1'b0;
        if (w_t === 1'b1) rq.wvalid <= 1'b0;
        n++;
    end while (b_t !== 1'b1 && n < 50);
    rq.bready <= 1'b0;
    chk("bvalid", 32'h0000_0001, 32'(b_t));
    chk("bresp", 32'h0000_0000, 32'(br));
endtask
task automatic rdr(input logic [11:0] a);
    int n;
    logic ar_t, r_t;
    @(posedge aclk);
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    rq.rready <= 1'b1;
    n = 0;
    do begin
        @(negedge aclk);
        ar_t = rq.arvalid && rs.arready;
        r_t = rs.rvalid;
        rd = rs.rdata;
        rr = rs.rresp;
        @(posedge aclk);
        if (ar_t === 1'b1) rq.arvalid <= 1'b0;
        n++;
    end while (r_t !== 1'b1 && n < 50);
    rq.rready <= 1'b0;
    chk("rvalid", 32'h0000_0001, 32'(r_t));
endtask
task automatic rchk(input string nm, input logic [11:0] a,
    input logic [31:0] e);
    rdr(a);
    chk(nm, e, rd);
endtask
function automatic logic [11:0] sa(input int g, input int s, input int f);
    return 12'h100 + 12'(g * 64 + s * 16 + f * 4);
endfunction
task automatic cfgs(input int s, input logic [31:0] p, input logic [31:0] c,
    input logic [31:0] d);
    wr(sa(0, s, 0), p);
    wr(sa(0, s, 2), c);
    wr(sa(0, s, 3), d);
endtask
task automatic cur(input logic [15:0] a, input logic [15:0] b,
    input logic [15:0] c, input int w);
    @(posedge aclk);
    ms.ia <= a;
    ms.ib <= b;
    ms.ic <= c;
    repeat (w) @(posedge aclk);
endtask
task automatic ttime(input int s, output int t);
    t = 0;
    while (trip[s] !== 1'b1 && t < 2000) begin
        @(negedge aclk);
        t++;
    end
endtask
////////////////////////////////////////
task automatic t_reset;
    rchk("ctrl", 12'h000, 32'h0000_6400);
    rchk("status", 12'h004, 32'h0000_0000);
    rdr(12'h008);
    chk("unmapped", 32'h0000_0002, 32'(rr));
endtask
task automatic t_dt;
    int tr [4] = '{0, 0, 0, 0};
    int t;
    for (int s = 0; s < 4; s++) cfgs(s, 32'h0000_0100, 32'h0000_0001, s + 1);
    cur(16'h00FF, 16'h0100, 16'h0050, 4);
    chk("no start", 32'h0000_0000, 32'(start));
    cur(16'h00FF, 16'h0100, 16'h0101, 0);
    for (int c = 1; c <= 100; c++) begin
        @(negedge aclk);
        if (c == 4) chk("start", 32'h0000_000F, 32'(start));
        for (int s = 0; s < 4; s++)
            if (trip[s] === 1'b1 && tr[s] == 0) tr[s] = c;
    end
    for (int s = 0; s < 4; s++)
        chk_rng("trip", (s + 1) * TK + 2, (s + 3) * TK + 4, tr[s]);
    wr(sa(0, 3, 3), 32'h0000_000A);
    cur(16'h0000, 16'h0000, 16'h0000, 4);
    chk("drop", 32'h0000_0000, 32'({start, trip}));
    cur(16'h0000, 16'h0000, 16'h0200, 20);
    cur(16'h0000, 16'h0000, 16'h0000, 4);
    cur(16'h0000, 16'h0000, 16'h0200, 0);
    ttime(3, t);
    chk_rng("restart", 10 * TK + 2, 13 * TK + 4, t);
endtask
task automatic t_dir;
    cfgs(0, 32'h0000_0100, 32'h0000_0003, 32'h0000_0FFF);
    rchk("mode3", sa(0, 0, 2), 32'h0000_0000);
    wr(sa(0, 0, 1), 32'h0000_01E2);
    for (int i = 0; i < 9; i++) begin
        wr(sa(0, 0, 2), 32'(tb[i][4]));
        @(posedge aclk);
        ms <= '{16'h0200, 16'h0, 16'h0, 9'(tb[i][0]), 9'(tb[i][1]),
            1'(tb[i][2]), 1'(tb[i][3])};
        repeat (4) @(posedge aclk);
        chk("sector", 32'(tb[i][5]), 32'(start[0]));
    end
endtask
task automatic t_scale;
    logic [31:0] pe [3] = '{32'h0000_0180, 32'h0000_0200, 32'h0000_0019};
    logic [7:0] pc [3] = '{8'h96, 8'hC8, 8'h0A};
    for (int i = 0; i < 3; i++) begin
        wr(12'h000, {16'h0000, pc[i], 8'h01});
        rchk("pick2", sa(1, 1, 0), pe[i]);
        if (i == 0) begin
            chk("grp2", 32'h0000_0001, 32'(active_grp2));
            rchk("cfg2", sa(1, 1, 2), 32'h0000_0001);
            cur(16'h0000, 16'h017F, 16'h0000, 4);
            chk("below", 32'h0000_0000, 32'(start[1]));
            cur(16'h0000, 16'h0181, 16'h0000, 4);
            chk("above", 32'h0000_0001, 32'(start[1]));
        end
    end
    wr(12'h000, 32'h0000_0501);
    rchk("pct keep", 12'h000, 32'h0000_0A01);
    wr(sa(1, 1, 0), 32'h0000_1234);
    rchk("pick2 keep", sa(1, 1, 0), 32'h0000_0019);
    wr(12'h000, 32'h0000_6400);
    chk("grp1", 32'h0000_0000, 32'(active_grp2));
endtask
task automatic t_sat;
    int t1;
    int t2;
    cfgs(0, 32'h0000_0100, 32'h0000_0005, 32'h0000_0064);
    cfgs(2, 32'h0000_0100, 32'h0000_0005, 32'h0000_0064);
    cur(16'h0000, 16'h0000, 16'h0000, 4);
    cur(16'h3200, 16'h0000, 16'h0000, 0);
    ttime(0, t1);
    cur(16'h0000, 16'h0000, 16'h0000, 4);
    cur(16'hFFFF, 16'h0000, 16'h0000, 0);
    ttime(0, t2);
    chk_rng("sat", t1 - TK + 1, t1 + TK - 1, t2);
    chk("fixed", 32'h0000_0000, 32'(trip[2]));
endtask
task automatic t_ce;
    @(posedge aclk);
    ce <= 1'b0;
    ms.ia <= 16'h0000;
    repeat (8) @(posedge aclk);
    chk("frozen", 32'h0000_0001, 32'(trip[0]));
    ce <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("thawed", 32'h0000_0000, 32'(trip[0]));
endtask
task automatic report_and_stop;
    $display("n_errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
////////////////////////////////////////
initial begin
    #100000;
    n_errors++;
    report_and_stop();
end
initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_dt();
    t_dir();
    t_scale();
    t_sat();
    t_ce();
    report_and_stop();
end
endmodule
`default_nettype wire
